// [design/pll_cfg_defines.svh]
/*
 * Constants of the fastlock and test mux configuration block:
 * control codes, field positions, reset values.
 * Assumes 24-bit words, control code in the low nibble.
 */
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

// word framing
`define WORD_BITS      24
`define CODE_MSB       3
`define CODE_LSB       0
`define CODE_MAIN_FL   4'h7
`define CODE_AUX_TOC   4'h9
`define CODE_MISC      4'hb

// field positions
`define SLIP_MSB       23
`define SLIP_LSB       22
`define TOC_MSB        15
`define TOC_LSB        4
`define SEL_MSB        7
`define SEL_LSB        4
`define DIFF_BIT       8
`define DBL_BIT        9

// reset values and limits
`define SLIP_RST       2'h0
`define TOC_RST        12'h000
`define SEL_RST        4'h0
`define TOC_FAST_MIN   12'h004

`endif

// [design/pll_cfg_pkg.sv]
/*
 * Types of the fastlock and test mux configuration block.
 * Assumes pll_cfg_defines.svh holds the numbers.
 */
package pll_cfg_pkg;

   // auxiliary fastlock sequencer
   typedef enum logic {
      FL_IDLE = 1'b0,
      FL_RUN  = 1'b1
   } fl_state_type;

   // stored configuration
   typedef struct packed {
      logic [1:0]  slip;
      logic [11:0] toc;
      logic [3:0]  sel;
      logic        diff;
      logic        dbl;
   } cfg_type;

   // lock detect levels
   typedef struct packed {
      logic main_dld;
      logic aux_dld;
      logic main_ald;
      logic aux_ald;
   } lock_type;

   // divider output pulses
   typedef struct packed {
      logic aux_r;
      logic aux_n;
      logic main_r;
      logic main_n;
   } div_type;

endpackage : pll_cfg_pkg

// [design/pll_cfg.sv]
/*
 * Configuration logic: serial word intake, slip reduction divider,
 * auxiliary fastlock timer and pin, test/lock-detect pin mux,
 * reference mode bits.
 * Assumes the host stops SER_CLK while SER_LE is high, and that tick,
 * lock and divider inputs come from logic on CORE_CLK.
 */
// What this block does
// - slip select 0..3 passes every 1st, 2nd, 4th, 16th main tick
// - words are 24 bits, code in bits 3..0, data above
// - timeout 0..3 keeps fastlock off, pin is general output
// - timeout 4..4095 enables fastlock, pin shows fastlock
// - fastlock lasts timeout count of auxiliary comparison ticks
// - timeout 0 hi-z, 1 low plus pump forced, 2 low, 3 high
// - test select 0 hi-z, 1 drives high, 2 drives low
// - test select 3..11 route digital and analog lock detect
// - test select 12..15 route halved divider outputs
// - diff mode bit picks single or differential reference
// - doubler bit 0 passes reference unchanged
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_defines.svh"

module pll_cfg
   import pll_cfg_pkg::*;
(
   // core clock and reset
   input  wire logic     CORE_CLK,
   input  wire logic     ARST_N,
   // serial port from host
   input  wire logic     SER_CLK,
   input  wire logic     SER_DATA,
   input  wire logic     SER_LE,
   // comparison ticks and retune request
   input  wire logic     MAIN_COMP_TICK,
   input  wire logic     AUX_COMP_TICK,
   input  wire logic     AUX_RETUNE,
   // lock detect and divider sources
   input  wire lock_type LOCK,
   input  wire div_type  DIV_TICK,
   // loop control outputs
   output logic          MAIN_SAMPLE_EN,
   output logic          AUX_FASTLOCK_ACTIVE,
   output logic          AUX_PUMP_FORCE_HI,
   // fastlock pin
   output logic          AUX_FASTLOCK_PIN_O,
   output logic          AUX_FASTLOCK_PIN_OE_N,
   // test / lock-detect pin
   output logic          TEST_LOCKDET_PIN_O,
   output logic          TEST_LOCKDET_PIN_OE_N,
   // reference input control
   output logic          REF_DIFF_MODE,
   output logic          REF_DOUBLER_EN
);

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------

   // last tick index of a slip reduction period
   function automatic logic [3:0] slip_last(input logic [1:0] s);
      unique case (s)
         2'h0: slip_last = 4'h0;
         2'h1: slip_last = 4'h1;
         2'h2: slip_last = 4'h3;
         2'h3: slip_last = 4'hf;
      endcase
   endfunction : slip_last

   // -----------------------------------------------------------
   // link domain: shift register
   // -----------------------------------------------------------
   logic [`WORD_BITS-1:0] shift_q;
   logic [`WORD_BITS-1:0] shift_d;

   // shift msb first while load enable is low
   always_comb begin
      shift_d = SER_LE ? shift_q : {shift_q[`WORD_BITS-2:0], SER_DATA};
   end

   always_ff @(posedge SER_CLK or negedge ARST_N) begin
      if (!ARST_N) shift_q <= '0;
      else         shift_q <= shift_d;
   end

   // -----------------------------------------------------------
   // core domain: load enable crossing
   // -----------------------------------------------------------
   logic [2:0] le_s_q;
   logic       le_lvl_q;
   logic [2:0] le_s_d;
   logic       le_lvl_d;
   logic       load;

   // three stages, change counts once stages two and three agree
   always_comb begin
      le_s_d   = {le_s_q[1:0], SER_LE};
      le_lvl_d = (le_s_q[1] == le_s_q[2]) ? le_s_q[2] : le_lvl_q;
      load     = le_s_q[1] & le_s_q[2] & ~le_lvl_q;
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         le_s_q   <= 3'h0;
         le_lvl_q <= 1'b0;
      end else begin
         le_s_q   <= le_s_d;
         le_lvl_q <= le_lvl_d;
      end
   end

   // -----------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------
   cfg_type    cfg_q;
   cfg_type    cfg_d;
   logic [3:0] code;

   // shift word is frozen while load enable is high
   always_comb begin
      code  = shift_q[`CODE_MSB:`CODE_LSB];
      cfg_d = cfg_q;
      if (load && code == `CODE_MAIN_FL)
         cfg_d.slip = shift_q[`SLIP_MSB:`SLIP_LSB];
      if (load && code == `CODE_AUX_TOC)
         cfg_d.toc = shift_q[`TOC_MSB:`TOC_LSB];
      if (load && code == `CODE_MISC) begin
         cfg_d.sel  = shift_q[`SEL_MSB:`SEL_LSB];
         cfg_d.diff = shift_q[`DIFF_BIT];
         cfg_d.dbl  = shift_q[`DBL_BIT];
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_q <= '{slip: `SLIP_RST, toc: `TOC_RST, sel: `SEL_RST,
                    diff: 1'b0, dbl: 1'b0};
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // -----------------------------------------------------------
   // slip reduction sample divider
   // -----------------------------------------------------------
   logic [3:0] slip_cnt_q;
   logic [3:0] slip_cnt_d;
   logic       sample_d;

   // pass one main tick in every 1, 2, 4 or 16
   always_comb begin
      slip_cnt_d = slip_cnt_q;
      sample_d   = 1'b0;
      if (MAIN_COMP_TICK) begin
         if (slip_cnt_q >= slip_last(cfg_q.slip)) begin
            slip_cnt_d = 4'h0;
            sample_d   = 1'b1;
         end else begin
            slip_cnt_d = slip_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         slip_cnt_q     <= 4'h0;
         MAIN_SAMPLE_EN <= 1'b0;
      end else begin
         slip_cnt_q     <= slip_cnt_d;
         MAIN_SAMPLE_EN <= sample_d;
      end
   end

   // -----------------------------------------------------------
   // auxiliary fastlock timer and pin
   // -----------------------------------------------------------
   fl_state_type fl_q;
   fl_state_type fl_d;
   logic [11:0]  fl_cnt_q;
   logic [11:0]  fl_cnt_d;
   logic         fast_mode;
   logic         fl_o_d;
   logic         fl_oe_n_d;
   logic         force_d;

   // start on retune or timeout change, leave after toc ticks
   // a write is judged on the new value, so 3 -> 4 starts a run
   always_comb begin
      fast_mode = cfg_q.toc >= `TOC_FAST_MIN;
      fl_d      = fl_q;
      fl_cnt_d  = fl_cnt_q;
      unique case (fl_q)
         FL_IDLE: begin
            if (cfg_d.toc >= `TOC_FAST_MIN
                && (AUX_RETUNE || cfg_d.toc != cfg_q.toc)) begin
               fl_d     = FL_RUN;
               fl_cnt_d = cfg_d.toc;
            end
         end
         FL_RUN: begin
            if (!fast_mode) begin
               fl_d = FL_IDLE;
            end else if (AUX_COMP_TICK) begin
               if (fl_cnt_q <= 12'h001) fl_d = FL_IDLE;
               else fl_cnt_d = fl_cnt_q - 12'h001;
            end
         end
      endcase
      // pin levels
      force_d   = 1'b0;
      fl_o_d    = 1'b0;
      fl_oe_n_d = 1'b1;
      if (fast_mode) begin
         fl_oe_n_d = (fl_q != FL_RUN);
      end else begin
         unique case (cfg_q.toc[1:0])
            2'h0: fl_oe_n_d = 1'b1;
            2'h1: begin
               fl_oe_n_d = 1'b0;
               force_d   = 1'b1;
            end
            2'h2: fl_oe_n_d = 1'b0;
            2'h3: begin
               fl_oe_n_d = 1'b0;
               fl_o_d    = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         fl_q                  <= FL_IDLE;
         fl_cnt_q              <= 12'h000;
         AUX_FASTLOCK_ACTIVE   <= 1'b0;
         AUX_PUMP_FORCE_HI     <= 1'b0;
         AUX_FASTLOCK_PIN_O    <= 1'b0;
         AUX_FASTLOCK_PIN_OE_N <= 1'b1;
      end else begin
         fl_q                  <= fl_d;
         fl_cnt_q              <= fl_cnt_d;
         AUX_FASTLOCK_ACTIVE   <= (fl_q == FL_RUN);
         AUX_PUMP_FORCE_HI     <= force_d;
         AUX_FASTLOCK_PIN_O    <= fl_o_d;
         AUX_FASTLOCK_PIN_OE_N <= fl_oe_n_d;
      end
   end

   // -----------------------------------------------------------
   // test / lock-detect pin mux
   // -----------------------------------------------------------
   div_type half_q;
   div_type half_d;
   logic    both_dld;
   logic    both_ald;
   logic    tst_o_d;
   logic    tst_oe_n_d;

   // halve each divider output by toggling on its pulse
   always_comb begin
      half_d     = half_q ^ DIV_TICK;
      both_dld   = LOCK.main_dld & LOCK.aux_dld;
      both_ald   = LOCK.main_ald & LOCK.aux_ald;
      tst_o_d    = 1'b0;
      tst_oe_n_d = 1'b0;
      unique case (cfg_q.sel)
         4'h0: tst_oe_n_d = 1'b1;
         4'h1: tst_o_d = 1'b1;
         4'h2: tst_o_d = 1'b0;
         4'h3: tst_o_d = both_dld;
         4'h4: tst_o_d = LOCK.main_dld;
         4'h5: tst_o_d = LOCK.aux_dld;
         4'h6: tst_oe_n_d = both_ald;
         4'h7: tst_oe_n_d = LOCK.main_ald;
         4'h8: tst_oe_n_d = LOCK.aux_ald;
         4'h9: tst_o_d = both_ald;
         4'ha: tst_o_d = LOCK.main_ald;
         4'hb: tst_o_d = LOCK.aux_ald;
         4'hc: tst_o_d = half_q.aux_r;
         4'hd: tst_o_d = half_q.aux_n;
         4'he: tst_o_d = half_q.main_r;
         4'hf: tst_o_d = half_q.main_n;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         half_q                <= '0;
         TEST_LOCKDET_PIN_O    <= 1'b0;
         TEST_LOCKDET_PIN_OE_N <= 1'b1;
         REF_DIFF_MODE         <= 1'b0;
         REF_DOUBLER_EN        <= 1'b0;
      end else begin
         half_q                <= half_d;
         TEST_LOCKDET_PIN_O    <= tst_o_d;
         TEST_LOCKDET_PIN_OE_N <= tst_oe_n_d;
         REF_DIFF_MODE         <= cfg_q.diff;
         REF_DOUBLER_EN        <= cfg_q.dbl;
      end
   end

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   sequence fl_entry;
      fl_q == FL_IDLE ##1 fl_q == FL_RUN;
   endsequence

   sequence fl_last_tick;
      fl_q == FL_RUN && AUX_COMP_TICK && fl_cnt_q <= 12'h001;
   endsequence

   chk_slip_off: assert property (
      cfg_q.slip == 2'h0 && MAIN_COMP_TICK |=> MAIN_SAMPLE_EN)
      else $error("sample missed with slip reduction off");

   chk_slip_half: assert property (
      cfg_q.slip == 2'h1 && MAIN_SAMPLE_EN && !load
      |-> !sample_d)
      else $error("half rate sampled twice in a row");

   chk_toc_route: assert property (
      load && code == `CODE_AUX_TOC
      |=> cfg_q.toc == $past(shift_q[`TOC_MSB:`TOC_LSB]))
      else $error("timeout word not stored");

   chk_misc_route: assert property (
      load && code == `CODE_MISC
      |=> cfg_q.sel == $past(shift_q[`SEL_MSB:`SEL_LSB]))
      else $error("misc word not stored");

   chk_gp_idle: assert property (
      cfg_q.toc < `TOC_FAST_MIN && cfg_d.toc < `TOC_FAST_MIN
      |=> fl_q == FL_IDLE)
      else $error("fastlock ran in general purpose mode");

   chk_fl_start: assert property (
      fl_entry |=> !AUX_FASTLOCK_PIN_OE_N && AUX_FASTLOCK_ACTIVE)
      else $error("fastlock pin not driven on entry");

   chk_fl_end: assert property (
      fl_last_tick |=> fl_q == FL_IDLE ##1 !AUX_FASTLOCK_ACTIVE)
      else $error("fastlock did not end on last tick");

   chk_manual: assert property (
      cfg_q.toc == 12'h001 |=> AUX_PUMP_FORCE_HI
      && !AUX_FASTLOCK_PIN_O && !AUX_FASTLOCK_PIN_OE_N)
      else $error("manual fastlock pin state wrong");

   chk_test_high: assert property (
      cfg_q.sel == 4'h1 |=> TEST_LOCKDET_PIN_O && !TEST_LOCKDET_PIN_OE_N)
      else $error("test pin not high");

   chk_test_dld: assert property (
      cfg_q.sel == 4'h4 |=> TEST_LOCKDET_PIN_O == $past(LOCK.main_dld))
      else $error("test pin lost main lock detect");

   chk_ref_bits: assert property (
      REF_DIFF_MODE == $past(cfg_q.diff)
      && REF_DOUBLER_EN == $past(cfg_q.dbl))
      else $error("reference control bits lag");

endmodule : pll_cfg

`default_nettype wire

// [bench/host_serial.sv]
/*
 * Host model: loads 24-bit words over the three-wire serial port.
 * Assumes the bench calls send and that nothing else drives the lines.
 */
`timescale 1ns/1ps
`default_nettype none

module host_serial (
   // three-wire port
   output logic sck,
   output logic sdat,
   output logic le
);
   // ------------------
   // word loader
   // ------------------
   // lines idle: clock still, load enable high
   initial begin
      sck = 1'b0;
      sdat = 1'b0;
      le = 1'b1;
   end

   // msb first, clock runs only inside the frame
   task automatic send(input logic [23:0] w);
      le = 1'b0;
      #24;
      for (int i = 23; i >= 0; i--) begin
         sdat = w[i];
         #24 sck = 1'b1;
         #24 sck = 1'b0;
      end
      sdat = ~sdat; // data no longer valid
      #24 le = 1'b1;
      #250; // hold high well beyond five core cycles
   endtask : send
endmodule : host_serial
`default_nettype wire

// [bench/tb_top.sv]
/*
 * Testbench: reference model of the stored words, compared with the
 * mux, slip divider, fastlock and reference outputs.
 * Assumes host_serial drives the serial port, 40 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import pll_cfg_pkg::*;
;
   // ------------------
   // signals and model
   // ------------------
   logic     core_clk, arst_n, lvl;
   logic [6:0] pls; // main, aux, retune, divider pulses
   lock_type lock;
   wire      ser_clk, ser_data, ser_le;
   logic     sample_en, fl_active, force_hi, fl_o, fl_oe_n;
   logic     tl_o, tl_oe_n, diff, dbl;
   int       miscompares = 0;
   int       num_checks = 0;
   int       en_cnt, n, m_diff, m_dbl;
   logic [3:0] fl_tab [4] = '{4'h2, 4'h4, 4'h0, 4'h1};

   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   // sample pulses seen
   always @(posedge core_clk) if (sample_en === 1'b1) en_cnt++;

   host_serial i_host (.sck(ser_clk), .sdat(ser_data), .le(ser_le));

   pll_cfg i_dut (
      .CORE_CLK(core_clk), .ARST_N(arst_n), .SER_CLK(ser_clk),
      .SER_DATA(ser_data), .SER_LE(ser_le), .MAIN_COMP_TICK(pls[0]),
      .AUX_COMP_TICK(pls[1]), .AUX_RETUNE(pls[2]), .LOCK(lock),
      .DIV_TICK(div_type'(pls[6:3])), .MAIN_SAMPLE_EN(sample_en),
      .AUX_FASTLOCK_ACTIVE(fl_active), .AUX_PUMP_FORCE_HI(force_hi),
      .AUX_FASTLOCK_PIN_O(fl_o), .AUX_FASTLOCK_PIN_OE_N(fl_oe_n),
      .TEST_LOCKDET_PIN_O(tl_o), .TEST_LOCKDET_PIN_OE_N(tl_oe_n),
      .REF_DIFF_MODE(diff), .REF_DOUBLER_EN(dbl));

   // ------------------
   // helpers
   // ------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int c);
      repeat (c) @(negedge core_clk);
   endtask : cyc

   // one-cycle pulse with a gap after it
   task automatic pulse(input int b);
      pls[b] <= 1'b1;
      @(negedge core_clk);
      pls[b] <= 1'b0;
      @(negedge core_clk);
   endtask : pulse

   // send a word and update the model
   task automatic load(input logic [3:0] code, input logic [19:0] d);
      i_host.send({d, code});
      if (code == 4'hb) begin
         m_diff = d[4];
         m_dbl = d[5];
      end
      cyc(4);
   endtask : load

   // expected {oe_n, o} of the test pin for select s below 12
   function automatic logic [1:0] mux_exp(input int s);
      logic mn, ax, v;
      if (s == 0) return 2'b10;
      if (s < 3) return {1'b0, s == 1};
      mn = (s < 6) ? lock.main_dld : lock.main_ald;
      ax = (s < 6) ? lock.aux_dld : lock.aux_ald;
      v = ((s - 3) % 3 == 0) ? (mn & ax) : (((s - 3) % 3 == 1) ? mn : ax);
      if (s >= 6 && s <= 8) return {v, 1'b0};
      return {1'b0, v};
   endfunction : mux_exp

   // fastlock run: count aux ticks until it ends
   task automatic run_fl(input int len);
      int k;
      k = 0;
      chk({fl_active, fl_oe_n, fl_o}, 3'b100);
      while (fl_active === 1'b1 && k < 5000) begin
         pulse(1);
         cyc(2);
         k++;
      end
      chk(16'(k), 16'(len));
      chk({fl_active, fl_oe_n}, 2'b01);
   endtask : run_fl

   task automatic tally_and_finish();
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // ------------------
   // tests
   // ------------------
   initial begin
      pls = '0;
      lock = '0;
      arst_n = 1'b0;
      void'($urandom(32'h58b5));
      cyc(8);
      chk({fl_active, force_hi, fl_oe_n, tl_oe_n, diff, dbl}, 6'h0c);
      arst_n = 1'b1;
      cyc(2);
      chk({fl_active, force_hi, fl_oe_n, tl_oe_n, diff, dbl}, 6'h0c);
      // test pin select, reference bits
      for (int s = 0; s < 16; s++) begin
         load(4'hb, {14'h0, 2'($urandom), 4'(s)});
         chk({diff, dbl}, {m_diff[0], m_dbl[0]});
         if (s < 12) begin
            repeat (4) begin
               lock = lock_type'(4'($urandom));
               cyc(3);
               chk({tl_oe_n, s == 0 ? 1'b0 : tl_o}, mux_exp(s));
            end
         end else begin
            lvl = tl_o;
            pulse(3 + ((16 - s) % 4));
            cyc(3);
            chk({tl_oe_n, tl_o}, {1'b0, lvl});
            pulse(18 - s);
            cyc(3);
            chk({tl_oe_n, tl_o}, {1'b0, ~lvl});
         end
      end
      // unknown codes leave the stored words alone
      load(4'h5, 20'hfffff);
      load(4'hd, 20'hfffff);
      chk({diff, dbl}, {m_diff[0], m_dbl[0]});
      // each slip reduction chosen by the host in turn
      for (int c = 0; c < 4; c++) begin
         load(4'h7, {2'(c), 18'h0});
         repeat (16) pulse(0);
         cyc(3);
         n = en_cnt;
         repeat (32) pulse(0);
         cyc(3);
         chk(16'(en_cnt - n), 16'(32 / ((c == 3) ? 16 : (1 << c))));
      end
      // general purpose pin codes, retune ignored
      for (int t = 0; t < 4; t++) begin
         load(4'h9, 20'(t));
         chk({fl_active, force_hi, fl_oe_n, t == 0 ? 1'b0 : fl_o}, fl_tab[t]);
      end
      pulse(2);
      cyc(2);
      chk(fl_active, 1'b0);
      // timed runs started by write and by retune
      for (int r = 0; r < 3; r++) begin
         n = 4 + 5 * r + ((r == 0) ? 0 : $urandom % 5);
         load(4'h9, 20'(n));
         run_fl(n);
         pulse(2);
         cyc(2);
         run_fl(n);
      end
      // abort by a low timeout in mid-run
      load(4'h9, 20'h8);
      pulse(1);
      load(4'h9, 20'h2);
      chk({fl_active, force_hi, fl_oe_n, fl_o}, fl_tab[2]);
      tally_and_finish();
   end

   // watchdog
   initial begin
      #1_000_000;
      miscompares++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
